/* File: src/pew_host.sv */
// host controller that drives the byte-wide nonvolatile memory through its pins
//
// Summary of operation
// RULE1 - a thirteen-bit byte address selects one of 8K byte locations.
// RULE2 - chip select is held low for every access, high otherwise for standby.
// RULE3 - a read runs while output strobe and select are both low.
// RULE4 - the memory floats its bus when either output strobe or select is high.
// RULE5 - writes happen only with select and write strobe low, output strobe high.
// RULE6 - address is taken by the later falling edge of select or write strobe.
// RULE7 - data is taken by the first rising edge of select or write strobe.
// RULE8 - one byte write then programs itself, nominally within two milliseconds.
// RULE9 - two to sixty-four loaded bytes program together in one cycle.
// RULE10 - the host keeps address bits six to twelve fixed within a page.
// RULE11 - after the first byte, one to sixty-three more may be loaded.
// RULE12 - each further byte load starts within 100 us of the last falling strobe.
// RULE13 - no falling strobe for 100 us closes the page and starts programming.
// RULE14 - while programming, the last address reads back inverted bit seven.
// RULE15 - after programming, bit seven reads true, marking completion.
// RULE16 - while programming, bit six inverts on every successive read.
// RULE17 - when programming ends bit six stops toggling and access resumes.
// RULE18 - any write is inhibited by output strobe low, write strobe or select high.
// RULE19 - writes during programming are ignored; reads give only status.
// RULE20 - load window and programming time are parameters for shorter simulation.
`timescale 1ns/1ps
`default_nettype none

module pew_host
	import pew_pkg::*;
#(
	// RULE20 shortenable timing
	parameter int LOAD_WINDOW = LOAD_WINDOW_CYC,
	parameter int PROG_TIME   = PROG_TIME_CYC,
	parameter int POLL_LIMIT  = 2 * PROG_TIME_CYC
)
(
	input  wire logic              sys_clk,
	input  wire logic              nrst,
	input  wire logic              req_valid,
	output logic                   req_ready,
	input  wire pew_req_t          req,
	output logic                   rsp_valid,
	output pew_rsp_t               rsp,
	output logic                   busy,
	output pew_pins_t              pins,
	input  wire logic [DATA_W-1:0] dq_in
);

	typedef enum {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_GAP, ST_WAIT} pew_state_t;

	pew_state_t        state;
	pew_req_t          cur;
	logic [15:0]       phase_cnt;
	logic [31:0]       gap_cnt;
	logic [31:0]       poll_cnt;
	logic [DATA_W-1:0] samp1;
	logic [DATA_W-1:0] samp2;
	logic [DATA_W-1:0] samp3;
	logic [DATA_W-1:0] prev_read;
	logic              have_prev;
	logic [6:0]        page_cnt;
	logic              load_open;
	logic [ADDR_W-PAGE_LSB-1:0] page_addr;
	logic [31:0]       prog_cnt;
	logic              poll_ok;

	function automatic logic is_write(input logic [1:0] op);
		is_write = (op == OP_WRITE);
	endfunction : is_write

	// -----------------------------------------------------------------
	// pin input synchroniser
	// -----------------------------------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			samp1 <= 8'h00;
			samp2 <= 8'h00;
			samp3 <= 8'h00;
		end
		else
		begin
			samp1 <= dq_in;
			samp2 <= samp1;
			samp3 <= samp2;
		end
	end

	// -----------------------------------------------------------------
	// access sequencer
	// -----------------------------------------------------------------
	// RULE19 no requests while programming
	assign req_ready = (state == ST_IDLE) && (prog_cnt == 32'h00000000);

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			state     <= ST_IDLE;
			cur       <= '0;
			phase_cnt <= 16'h0000;
		end
		else
		begin
			case (state)
				ST_IDLE:
				begin
					phase_cnt <= 16'h0000;
					if (req_valid && req_ready)
					begin
						cur   <= req;
						state <= ST_SETUP;
					end
				end
				ST_SETUP:
				begin
					phase_cnt <= phase_cnt + 16'h0001;
					if (phase_cnt == 16'(SETUP_CYC - 1))
					begin
						phase_cnt <= 16'h0000;
						state     <= ST_PULSE;
					end
				end
				ST_PULSE:
				begin
					phase_cnt <= phase_cnt + 16'h0001;
					if (phase_cnt == 16'(PULSE_CYC - 1))
					begin
						phase_cnt <= 16'h0000;
						state     <= ST_HOLD;
					end
				end
				ST_HOLD:
				begin
					phase_cnt <= phase_cnt + 16'h0001;
					if (phase_cnt == 16'(HOLD_CYC - 1))
					begin
						phase_cnt <= 16'h0000;
						// a poll that is not yet stable goes round again until poll_cnt reaches POLL_LIMIT
						if ((cur.op == OP_POLL || cur.op == OP_TOGGLE) && !poll_ok)
							state <= (poll_cnt >= 32'(POLL_LIMIT)) ? ST_IDLE : ST_SETUP;
						else if (is_write(cur.op) && cur.last)
							state <= ST_GAP;
						else
							state <= ST_IDLE;
					end
				end
				// RULE13 closing window
				ST_GAP:
				begin
					if (gap_cnt >= 32'(LOAD_WINDOW))
						state <= ST_WAIT;
				end
				// RULE19 no writes while programming
				ST_WAIT:
				begin
					if (prog_cnt == 32'h00000000 && !load_open)
						state <= ST_IDLE;
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// a process, not a function, so the result follows every sample it reads
	always_comb
	begin
		// RULE14 bit seven matches
		if (cur.op == OP_POLL)
			poll_ok = (samp3[DQ7] == cur.data[DQ7]) && (samp2[DQ7] == samp3[DQ7]);
		// RULE17 bit six repeats
		else
			poll_ok = have_prev && (samp3[DQ6] == prev_read[DQ6]);
	end

	// -----------------------------------------------------------------
	// page load window and programming time
	// -----------------------------------------------------------------
	logic strobe_fall;
	assign strobe_fall = (state == ST_SETUP) && (phase_cnt == 16'(SETUP_CYC - 1)) && is_write(cur.op);

	// RULE12 next load inside window
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			gap_cnt   <= 32'h00000000;
			load_open <= 1'b0;
			page_cnt  <= 7'h00;
			page_addr <= '0;
		end
		else if (strobe_fall)
		begin
			gap_cnt   <= 32'h00000000;
			load_open <= 1'b1;
			// RULE9 RULE11 page count
			page_cnt  <= load_open ? page_cnt + 7'h01 : 7'h01;
			if (!load_open)
				page_addr <= cur.addr[ADDR_W-1:PAGE_LSB];
		end
		else if (load_open)
		begin
			gap_cnt <= gap_cnt + 32'h00000001;
			if (gap_cnt >= 32'(LOAD_WINDOW))
				load_open <= 1'b0;
		end
	end

	// RULE8 programming timer
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			prog_cnt <= 32'h00000000;
		else if (load_open && gap_cnt >= 32'(LOAD_WINDOW))
			prog_cnt <= 32'(PROG_TIME);
		else if (prog_cnt != 32'h00000000)
			prog_cnt <= prog_cnt - 32'h00000001;
	end
	assign busy = load_open || (prog_cnt != 32'h00000000) || (state == ST_GAP) || (state == ST_WAIT);

	// -----------------------------------------------------------------
	// read capture and answers
	// -----------------------------------------------------------------
	logic read_end;
	// kept at the decision edge so the toggle compare still sees the previous read
	assign read_end = (state == ST_HOLD) && (phase_cnt == 16'(HOLD_CYC - 1)) && !is_write(cur.op);

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			poll_cnt  <= 32'h00000000;
			prev_read <= 8'h00;
			have_prev <= 1'b0;
		end
		else if (state == ST_IDLE)
		begin
			poll_cnt  <= 32'h00000000;
			have_prev <= 1'b0;
		end
		// RULE16 toggle compare
		else if (read_end)
		begin
			poll_cnt  <= poll_cnt + 32'h00000001;
			prev_read <= samp3;
			have_prev <= 1'b1;
		end
	end

	logic done_now;
	assign done_now = (state == ST_HOLD) && (phase_cnt == 16'(HOLD_CYC - 1))
		&& !(cur.op != OP_READ && cur.op != OP_WRITE && !poll_ok && poll_cnt < 32'(POLL_LIMIT));

	// RULE15 completion on true bit seven
	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
		begin
			rsp_valid <= 1'b0;
			rsp       <= '0;
		end
		else
		begin
			rsp_valid <= done_now;
			if (done_now)
			begin
				rsp.data    <= samp3;
				rsp.timeout <= (cur.op == OP_POLL || cur.op == OP_TOGGLE) && !poll_ok;
			end
		end
	end

	// -----------------------------------------------------------------
	// pin drive
	// -----------------------------------------------------------------
	logic active;
	assign active = (state == ST_SETUP) || (state == ST_PULSE) || (state == ST_HOLD);

	always_ff @(posedge sys_clk)
	begin
		if (!nrst)
			pins <= '{byte_address: '0, sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0};
		else
		begin
			// RULE1 RULE6 address before strobe
			pins.byte_address <= cur.addr;
			// RULE2 select only during access
			pins.sel_n        <= !active;
			// RULE3 read strobe
			pins.oe_n         <= !(active && !is_write(cur.op) && !(state == ST_HOLD));
			// RULE5 write strobe with output strobe high
			pins.we_n         <= !(state == ST_PULSE && is_write(cur.op));
			// RULE7 data across strobe rise
			pins.dq_out       <= cur.data;
			// RULE4 bus driven by the host only on writes
			pins.dq_oe        <= active && is_write(cur.op);
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	AST_WRITE_FORM: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE5
		!pins.we_n |-> (!pins.sel_n && pins.oe_n && pins.dq_oe)) else $error("write strobe without select");
	AST_NO_FIGHT: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE18
		!pins.oe_n |-> (pins.we_n && !pins.dq_oe)) else $error("read strobe while driving");
	AST_STANDBY: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE2
		(state == ST_IDLE && $past(state) == ST_IDLE) |-> pins.sel_n) else $error("select while idle");
	AST_DATA_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE7
		$rose(pins.we_n) |-> pins.dq_oe && $stable(pins.dq_out)) else $error("data changed at strobe rise");
	AST_ADDR_STABLE: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE6
		(!pins.we_n && !$past(pins.we_n)) |-> $stable(pins.byte_address)) else $error("address moved in strobe");
	AST_PAGE_ADDR: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE10
		(strobe_fall && load_open) |-> cur.addr[ADDR_W-1:PAGE_LSB] == page_addr) else $error("page address changed");
	AST_PAGE_SIZE: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE9
		page_cnt <= 7'(PAGE_BYTES)) else $error("page over sixty-four bytes");
	AST_NO_WRITE_BUSY: assert property (@(posedge sys_clk) disable iff (!nrst) // RULE19
		(prog_cnt != 32'h00000000) |-> pins.we_n) else $error("write during programming");

endmodule : pew_host

`default_nettype wire

/* File: src/pew_pkg.sv */
// shared constants and carrier types for the page-write memory host controller
package pew_pkg;

	localparam int ADDR_W          = 13;
	localparam int DATA_W          = 8;
	localparam int PAGE_LSB        = 6;
	localparam int PAGE_BYTES      = 64;
	localparam int CLK_PERIOD_PS   = 8000;
	// byte-load window, in ns
	localparam int LOAD_WINDOW_NS  = 100000;
	// the whole window in cycles; the host closes the page after this long without a falling write strobe
	localparam int LOAD_WINDOW_CYC = (LOAD_WINDOW_NS * 1000) / CLK_PERIOD_PS;
	// nominal programming time, in us
	localparam int PROG_TIME_US    = 2000;
	localparam int PROG_TIME_CYC   = (PROG_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
	// strobe phase lengths in cycles, covering the part's access time
	localparam int SETUP_CYC       = 2;
	localparam int PULSE_CYC       = 13;
	localparam int HOLD_CYC        = 2;
	localparam logic [1:0] OP_READ   = 2'h0;
	localparam logic [1:0] OP_WRITE  = 2'h1;
	localparam logic [1:0] OP_POLL   = 2'h2;
	localparam logic [1:0] OP_TOGGLE = 2'h3;
	localparam int DQ7             = 7;
	localparam int DQ6             = 6;

	typedef struct packed {
		logic [1:0]        op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic              last;
	} pew_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              timeout;
	} pew_rsp_t;

	typedef struct packed {
		logic [ADDR_W-1:0] byte_address;
		logic              sel_n;
		logic              oe_n;
		logic              we_n;
		logic [DATA_W-1:0] dq_out;
		logic              dq_oe;
	} pew_pins_t;

endpackage : pew_pkg

/* File: testbench/pew_mem_model.sv */
// behavioural model of the byte-wide page-write memory seen from its pins
`timescale 1ns/1ps
`default_nettype none

module pew_mem_model
	import pew_pkg::*;
#(
	parameter int LOAD_WIN = 40,
	parameter int PROG     = 600
)
(
	input  wire logic              sys_clk,
	input  wire pew_pins_t         pins,
	output logic [DATA_W-1:0]      dev_q
);
	// ------------------------------
	// storage and page buffer
	// ------------------------------
	logic [DATA_W-1:0]     mem [0:(1<<ADDR_W)-1];
	logic [DATA_W-1:0]     pbuf [0:PAGE_BYTES-1];
	logic [PAGE_BYTES-1:0] pval;
	logic [ADDR_W-1:0]     wa;
	logic [DATA_W-1:0]     last_d;
	logic [DATA_W-1:0]     held;
	logic                  wr, rd, wr_q, rd_q, loading, tog;
	int                    win, prog;

	assign wr = !pins.sel_n && !pins.we_n && pins.oe_n;
	assign rd = !pins.sel_n && !pins.oe_n;

	initial
	begin
		foreach (mem[i]) mem[i] = 8'hFF;
		{pval, wr_q, rd_q, loading, tog, win, prog, held, last_d, wa} = '0;
	end

	// sampled on the falling clock so the host's registered pins have settled
	always @(negedge sys_clk)
	begin
		// address on later fall, ignored while programming
		if (wr && !wr_q && prog == 0)
		begin
			wa = pins.byte_address;
			loading = 1'b1;
			win = 0;
		end
		// data on first rise into page buffer
		if (!wr && wr_q && loading)
		begin
			pbuf[wa[PAGE_LSB-1:0]] = pins.dq_out;
			pval[wa[PAGE_LSB-1:0]] = 1'b1;
			last_d = pins.dq_out;
		end
		if (loading && !wr && ++win > LOAD_WIN)
		begin
			for (int i = 0; i < PAGE_BYTES; i++)
				if (pval[i]) mem[{wa[ADDR_W-1:PAGE_LSB], 6'(i)}] = pbuf[i];
			{pval, loading} = '0;
			prog = PROG;
		end
		else if (prog > 0)
			prog--;
		// bit six flips per read only while programming
		if (rd && !rd_q && prog > 0)
			tog = ~tog;
		if (rd)
			held = dev_q;
		wr_q = wr;
		rd_q = rd;
	end

	// released bus shows inverse, not a stale value
	always_comb
		if (!rd)
			dev_q = ~held;
		else if (prog > 0)
			dev_q = {~last_d[DQ7], tog, last_d[5:0]};
		else
			dev_q = mem[pins.byte_address];

endmodule : pew_mem_model

`default_nettype wire

/* File: testbench/testbench.sv */
// self-checking testbench for the page-write memory host controller
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import pew_pkg::*;
	logic              sys_clk, nrst, req_valid, req_ready, rsp_valid, busy;
	pew_req_t          req;
	pew_rsp_t          rsp;
	pew_pins_t         pins;
	logic [DATA_W-1:0] dq_in, dev_q;
	int                num_errors, n_compared;

	// host programming time short so polls meet the model still busy
	pew_host #(.LOAD_WINDOW(50), .PROG_TIME(20), .POLL_LIMIT(400)) pew_host_i (.sys_clk(sys_clk), .nrst(nrst),
		.req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
		.busy(busy), .pins(pins), .dq_in(dq_in));
	pew_mem_model #(.LOAD_WIN(40), .PROG(600)) pew_mem_model_i (.sys_clk(sys_clk), .pins(pins), .dev_q(dev_q));
	assign dq_in = pins.dq_oe ? pins.dq_out : dev_q;

	// ------------------------------
	// shared tasks
	// ------------------------------
	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic step(inout int n);
		@(posedge sys_clk);
		#1;
		if (++n > 20000)
		begin
			num_errors++;
			$display("MISMATCH handshake expected done seen none");
			end_sim;
		end
	endtask : step

	task automatic do_req(input logic [1:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic l);
		int n;
		n = 0;
		while (req_ready !== 1'b1)
			step(n);
		req_valid = 1'b1;
		req = '{op: op, addr: a, data: d, last: l};
		step(n);
		req_valid = 1'b0;
		while (rsp_valid !== 1'b1)
			step(n);
	endtask : do_req

	// watches the pins for contention and stray write strobes
	always @(negedge sys_clk)
		if (nrst === 1'b1)
		begin
			if (pins.we_n === 1'b0)
				chk("wr_sel", {pins.oe_n, pins.sel_n}, 16'h2);
			if (pins.oe_n === 1'b0)
				chk("rd_oe", {pins.dq_oe, pins.sel_n}, 16'h0);
		end

	// ------------------------------
	// scenarios
	// ------------------------------
	task t_reset;
		chk("idle", {pins.sel_n, pins.oe_n, pins.we_n, pins.dq_oe, req_ready}, 16'h1D);
	endtask : t_reset

	task t_byte;
		do_req(OP_WRITE, 13'h0123, 8'h5A, 1'b1);
		chk("busy", {15'h0, busy}, 16'h1);
		do_req(OP_POLL, 13'h0123, 8'h5A, 1'b0);
		chk("poll", {rsp.timeout, rsp.data}, 16'h05A);
		do_req(OP_READ, 13'h0123, 8'h00, 1'b0);
		chk("rdback", rsp.data, 16'h5A);
		do_req(OP_READ, 13'h1123, 8'h00, 1'b0);
		chk("decode", rsp.data, 16'hFF);
	endtask : t_byte

	task t_page;
		// one page, loads back to back
		for (int i = 0; i < 3; i++)
			do_req(OP_WRITE, 13'h0A40 + 13'(i), 8'hC0 + 8'(i), i == 2);
		chk("closing", {15'h0, req_ready}, 16'h0);
		do_req(OP_TOGGLE, 13'h0A42, 8'h00, 1'b0);
		chk("toggle", {7'h00, rsp.timeout, rsp.data}, 16'h00C2);
		for (int i = 0; i < 3; i++)
		begin
			do_req(OP_READ, 13'h0A40 + 13'(i), 8'h00, 1'b0);
			chk("page", rsp.data, 16'h00C0 + 16'(i));
		end
		do_req(OP_WRITE, 13'h0A41, 8'h33, 1'b1);
		do_req(OP_POLL, 13'h0A41, 8'h33, 1'b0);
		chk("rewrite", rsp.data, 16'h33);
		do_req(OP_POLL, 13'h0A41, 8'hB3, 1'b0);
		chk("giveup", {7'h00, rsp.timeout, rsp.data}, 16'h0133);
	endtask : t_page

	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	initial
	begin
		{num_errors, n_compared} = '0;
		nrst = 1'b0;
		req_valid = 1'b0;
		req = '0;
		repeat (4) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		t_reset;
		t_byte;
		t_page;
		end_sim;
	end

endmodule : testbench

`default_nettype wire
